// *** hw/agu_regs.svh ***
// Constants for the circular address unit: register offsets, field positions, resets.
// Assumes a 32-bit AXI4-Lite register bus and a 32-bit data address space.
`ifndef AGU_REGS_SVH
`define AGU_REGS_SVH
`define AGU_IDX_BASE 8'h00
`define AGU_MOD_BASE 8'h10
`define AGU_BAS_BASE 8'h20
`define AGU_LEN_BASE 8'h30
`define AGU_PTR_BASE 8'h40
`define AGU_STAT 8'h60
`define AGU_LAST 8'h64
`define AGU_REG_RESET 32'h00000000
`define AGU_STAT_FAULT 0
`define AGU_STAT_BAD 1
`define AGU_STAT_VALID 2
`define AGU_NUM_IDX 4
`define AGU_NUM_PTR 8
`define AGU_RESP_OKAY 2'h0
`define AGU_RESP_SLVERR 2'h2
`endif

// *** hw/agu_pkg.sv ***
// Types shared by the address unit, its checker and the testbench.
// Assumes the constants header is visible to its includers.
package agu_pkg;
   // Operation kinds issued by the decode stage.
   typedef enum logic [1:0] {OP_NONE = 2'h0, OP_ACCESS = 2'h1, OP_MODIFY = 2'h2} op_t;
   // Transfer size of an access.
   typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} size_t;
   // Modifier source select.
   typedef enum logic [1:0] {MOD_MREG = 2'h0, MOD_PREG = 2'h1, MOD_IMM = 2'h2} modsrc_t;
   // Bus slave write states, one-hot.
   typedef enum logic [2:0] {WS_IDLE = 3'h1, WS_WAIT = 3'h2, WS_RESP = 3'h4} wstate_t;
endpackage

// *** hw/agu_wrap.sv ***
// Circular wrap datapath: adds a modifier to an index and folds it into its buffer.
// Assumes purely combinational use from the same clock domain.
`timescale 1ns/1ns
module agu_wrap
#(
   parameter int WIDTH = 32
)
(
   // Operands.
   input wire logic [WIDTH-1:0] IDX_OLD,
   input wire logic [WIDTH-1:0] MODIFIER,
   input wire logic [WIDTH-1:0] BASE,
   input wire logic [WIDTH-1:0] LENGTH,
   input wire logic CIRC_EN,
   // Result.
   output logic [WIDTH-1:0] IDX_NEW
);
   initial
   begin
      if (WIDTH != 32)
      begin
         $error("agu_wrap supports a 32-bit address width only");
      end
   end

   // Modulo sums, never saturated.
   // wrapping arithmetic
   wire [WIDTH-1:0] sum = IDX_OLD + MODIFIER;
   wire [WIDTH:0] end_addr = {1'b0, BASE} + {1'b0, LENGTH};
   wire neg_mod = MODIFIER[WIDTH-1];
   wire over_end = {1'b0, sum} >= end_addr;
   wire under_base = sum < BASE;
   wire [WIDTH-1:0] wrap_dn = sum - LENGTH;
   wire [WIDTH-1:0] wrap_up = sum + LENGTH;
   wire do_dn = CIRC_EN && (LENGTH != '0) && !neg_mod && over_end;
   wire do_up = CIRC_EN && (LENGTH != '0) && neg_mod && under_base;
   assign IDX_NEW = do_dn ? wrap_dn : (do_up ? wrap_up : sum);
endmodule

// *** hw/agu_top.sv ***
// Circular data address generator with AXI4-Lite register access.
// Assumes the decode stage issues at most one operation per cycle on CLK_SYS.
`include "agu_regs.svh"
`timescale 1ns/1ns
module agu_top
   import agu_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Decode stage request.
   input wire logic OP_VALID,
   input wire agu_pkg::op_t OP_KIND,
   input wire logic OP_USE_PTR,
   input wire logic [2:0] OP_REG,
   input wire agu_pkg::modsrc_t OP_MODSRC,
   input wire logic [2:0] OP_MODREG,
   input wire logic [31:0] OP_IMM,
   input wire agu_pkg::size_t OP_SIZE,
   input wire logic OP_IS_LOAD,
   input wire logic OP_DEST_PTR,
   input wire logic OP_POSTMOD,
   input wire logic OP_IMPLICIT_NOALIGN,
   input wire logic OP_SUPPRESS_OP,
   // Data memory address.
   output logic MEM_VALID,
   output logic [31:0] MEM_ADDR,
   output logic ALIGN_FAULT,
   output logic OP_REFUSED,
   // AXI4-Lite slave.
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import agu_pkg::*;

   logic [31:0] idx_r [`AGU_NUM_IDX];
   logic [31:0] mod_r [`AGU_NUM_IDX];
   logic [31:0] bas_r [`AGU_NUM_IDX];
   logic [31:0] len_r [`AGU_NUM_IDX];
   logic [31:0] ptr_r [`AGU_NUM_PTR];
   logic fault_r, bad_r, valid_r;
   logic [31:0] last_r;

   // Operand selection; the same number picks index, base and length.
   wire [1:0] isel = OP_REG[1:0];
   wire [31:0] reg_old = OP_USE_PTR ? ptr_r[OP_REG] : idx_r[isel];
   wire mod_ok = OP_USE_PTR ? (OP_MODSRC != MOD_MREG) : (OP_MODSRC != MOD_PREG);
   wire [31:0] modval = (OP_MODSRC == MOD_IMM) ? OP_IMM :
                        (OP_MODSRC == MOD_PREG) ? ptr_r[OP_MODREG] : mod_r[OP_MODREG[1:0]];

   wire [31:0] idx_new;
   agu_wrap #(.WIDTH(32)) u_wrap
   (
      .IDX_OLD(reg_old),
      .MODIFIER(modval),
      .BASE(bas_r[isel]),
      .LENGTH(len_r[isel]),
      .CIRC_EN(!OP_USE_PTR),
      .IDX_NEW(idx_new)
   );
   // Pointers never wrap, so the wrap module passes the plain sum through.

   wire pm_bad = OP_KIND == OP_ACCESS && OP_POSTMOD &&
                 (OP_SIZE == SZ_BYTE || (OP_IS_LOAD && OP_DEST_PTR));
   wire byte_idx = OP_KIND == OP_ACCESS && !OP_USE_PTR && OP_SIZE == SZ_BYTE;
   wire refuse = OP_VALID && (pm_bad || byte_idx || !mod_ok ||
                 (OP_KIND == OP_NONE));
   wire acc = OP_VALID && !refuse && OP_KIND == OP_ACCESS;
   wire upd = OP_VALID && !refuse && (OP_KIND == OP_MODIFY || OP_POSTMOD);

   wire misalign = (OP_SIZE == SZ_WORD && reg_old[1:0] != 2'h0) ||
                   (OP_SIZE == SZ_HALF && reg_old[0] != 1'b0);
   wire suppress = OP_IMPLICIT_NOALIGN || (OP_SUPPRESS_OP && OP_IS_LOAD && !OP_USE_PTR);
   wire fault = acc && misalign && !suppress;

   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         MEM_VALID <= 1'b0;
         MEM_ADDR <= `AGU_REG_RESET;
         ALIGN_FAULT <= 1'b0;
         OP_REFUSED <= 1'b0;
      end
      else
      begin
         MEM_VALID <= acc && !fault;
         MEM_ADDR <= acc ? reg_old : MEM_ADDR;
         ALIGN_FAULT <= fault;
         OP_REFUSED <= refuse;
      end
   end

   // Bus write decode.
   logic [7:0] waddr_r;
   logic aw_got_r, w_got_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   wstate_t ws_r;
   wire wfire = aw_got_r && w_got_r && ws_r != WS_RESP;
   wire [2:0] wgrp = waddr_r[6:4];
   wire [2:0] wsub = waddr_r[4:2];
   wire wmap = waddr_r[1:0] == 2'h0 && (waddr_r < `AGU_PTR_BASE + 8'h20);
   wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   // Status and last-address words answer OKAY; a write to the last address is ignored.
   wire wok = wmap || waddr_r == `AGU_STAT || waddr_r == `AGU_LAST;

   assign S_AXI_AWREADY = !aw_got_r && ws_r != WS_RESP;
   assign S_AXI_WREADY = !w_got_r && ws_r != WS_RESP;
   assign S_AXI_BVALID = ws_r == WS_RESP;

   // Write channel capture and response; address and data in either order.
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         ws_r <= WS_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= `AGU_REG_RESET;
         wstrb_r <= 4'h0;
         S_AXI_BRESP <= `AGU_RESP_OKAY;
      end
      else
      begin
         case (ws_r)
            WS_IDLE, WS_WAIT:
            begin
               if (S_AXI_AWVALID && S_AXI_AWREADY)
               begin
                  waddr_r <= S_AXI_AWADDR;
                  aw_got_r <= 1'b1;
               end
               if (S_AXI_WVALID && S_AXI_WREADY)
               begin
                  wdata_r <= S_AXI_WDATA;
                  wstrb_r <= S_AXI_WSTRB;
                  w_got_r <= 1'b1;
               end
               if (wfire)
               begin
                  ws_r <= WS_RESP;
                  S_AXI_BRESP <= wok ? `AGU_RESP_OKAY : `AGU_RESP_SLVERR;
               end
               else
               begin
                  ws_r <= WS_WAIT;
               end
            end
            WS_RESP:
            begin
               if (S_AXI_BREADY)
               begin
                  ws_r <= WS_IDLE;
                  aw_got_r <= 1'b0;
                  w_got_r <= 1'b0;
               end
            end
            default:
            begin
               ws_r <= WS_IDLE;
            end
         endcase
      end
   end

   // Register file: decode updates win over bus writes to the same register.
   genvar g;
   generate
      for (g = 0; g < `AGU_NUM_PTR; g++)
      begin : g_reg
         wire bus_p = wfire && wmap && wgrp >= 3'h4 && wsub == 3'(g);
         wire op_p = upd && OP_USE_PTR && OP_REG == 3'(g);
         always_ff @(posedge CLK_SYS or negedge NRST)
         begin
            if (!NRST)
            begin
               ptr_r[g] <= `AGU_REG_RESET;
            end
            else if (op_p)
            begin
               ptr_r[g] <= idx_new;
            end
            else if (bus_p)
            begin
               ptr_r[g] <= (ptr_r[g] & ~wmask) | (wdata_r & wmask);
            end
         end
         if (g < `AGU_NUM_IDX)
         begin : g_dag
            wire hit = wfire && wmap && wsub[1:0] == 2'(g);
            wire op_i = upd && !OP_USE_PTR && isel == 2'(g);
            always_ff @(posedge CLK_SYS or negedge NRST)
            begin
               if (!NRST)
               begin
                  idx_r[g] <= `AGU_REG_RESET;
                  mod_r[g] <= `AGU_REG_RESET;
                  bas_r[g] <= `AGU_REG_RESET;
                  len_r[g] <= `AGU_REG_RESET;
               end
               else
               begin
                  if (op_i)
                     idx_r[g] <= idx_new;
                  else if (hit && wgrp == 3'h0)
                     idx_r[g] <= (idx_r[g] & ~wmask) | (wdata_r & wmask);
                  if (hit && wgrp == 3'h1)
                     mod_r[g] <= (mod_r[g] & ~wmask) | (wdata_r & wmask);
                  if (hit && wgrp == 3'h2)
                     bas_r[g] <= (bas_r[g] & ~wmask) | (wdata_r & wmask);
                  if (hit && wgrp == 3'h3)
                     len_r[g] <= (len_r[g] & ~wmask) | (wdata_r & wmask);
               end
            end
         end
      end
   endgenerate

   // Sticky status: hardware set wins over a bus write-one clear.
   wire stat_wr = wfire && waddr_r == `AGU_STAT && wstrb_r[0];
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         fault_r <= 1'b0;
         bad_r <= 1'b0;
         valid_r <= 1'b0;
         last_r <= `AGU_REG_RESET;
      end
      else
      begin
         fault_r <= fault || (fault_r && !(stat_wr && wdata_r[`AGU_STAT_FAULT]));
         bad_r <= refuse || (bad_r && !(stat_wr && wdata_r[`AGU_STAT_BAD]));
         valid_r <= acc || (valid_r && !(stat_wr && wdata_r[`AGU_STAT_VALID]));
         last_r <= acc ? reg_old : last_r;
      end
   end

   // Read channel.
   wire [7:0] ra = S_AXI_ARADDR;
   wire [2:0] rgrp = ra[6:4];
   wire [1:0] rsub = ra[3:2];
   wire rmap_dag = ra[1:0] == 2'h0 && ra < `AGU_PTR_BASE;
   wire rmap_ptr = ra[1:0] == 2'h0 && ra >= `AGU_PTR_BASE && ra < `AGU_PTR_BASE + 8'h20;
   wire [31:0] dag_word = rgrp == 3'h0 ? idx_r[rsub] : rgrp == 3'h1 ? mod_r[rsub] :
                          rgrp == 3'h2 ? bas_r[rsub] : len_r[rsub];
   wire [31:0] stat_word = {29'h0, valid_r, bad_r, fault_r};
   wire rok = rmap_dag || rmap_ptr || ra == `AGU_STAT || ra == `AGU_LAST;
   wire [31:0] rword = rmap_dag ? dag_word : rmap_ptr ? ptr_r[ra[4:2]] :
                       ra == `AGU_STAT ? stat_word : ra == `AGU_LAST ? last_r : 32'h0;
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   // Read data is registered one cycle after the address is taken.
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `AGU_RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rword;
         S_AXI_RRESP <= rok ? `AGU_RESP_OKAY : `AGU_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule

// *** sim/mem_bus_model.sv ***
// Data memory bus model: counts issued accesses and keeps the last address.
// Assumes the address unit's registered access strobe on the same clock.
`timescale 1ns/1ns
module mem_bus_model
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Access from the address unit.
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   // Observations.
   output int n_access,
   output logic [31:0] last_addr
);
   // address with strobe: the bus takes the address shown with the strobe.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         n_access <= 0;
         last_addr <= 32'h0;
      end
      else if (mem_valid)
      begin
         n_access <= n_access + 1;
         last_addr <= mem_addr;
      end
   end
endmodule

// *** sim/agu_checker.sv ***
// Concurrent checks on the address unit's decode side ports.
// Assumes it is bound to agu_top and sees only its ports.
`timescale 1ns/1ns
module agu_checker
   import agu_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_SYS,
   input wire logic NRST,
   // Request.
   input wire logic OP_VALID,
   input wire agu_pkg::op_t OP_KIND,
   input wire logic OP_USE_PTR,
   input wire agu_pkg::modsrc_t OP_MODSRC,
   input wire agu_pkg::size_t OP_SIZE,
   input wire logic OP_IS_LOAD,
   input wire logic OP_DEST_PTR,
   input wire logic OP_POSTMOD,
   input wire logic OP_IMPLICIT_NOALIGN,
   input wire logic OP_SUPPRESS_OP,
   // Answer.
   input wire logic MEM_VALID,
   input wire logic [31:0] MEM_ADDR,
   input wire logic ALIGN_FAULT,
   input wire logic OP_REFUSED
);
   // All checks run on the core clock and rest during reset.
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   mem_needs_access_a: assert property (MEM_VALID
      |-> $past(OP_VALID && OP_KIND == OP_ACCESS)) else $error("Access without request.");
   modify_no_access_a: assert property (OP_VALID && OP_KIND == OP_MODIFY
      |=> !MEM_VALID && !ALIGN_FAULT) else $error("Modify reached memory.");
   class_refused_a: assert property (OP_VALID && OP_KIND != OP_NONE
      && (OP_KIND == OP_MODIFY || OP_POSTMOD) && OP_MODSRC == (OP_USE_PTR ? MOD_MREG : MOD_PREG)
      |=> OP_REFUSED) else $error("Wrong modifier class taken.");
   postmod_refused_a: assert property (OP_VALID && OP_KIND == OP_ACCESS && (OP_POSTMOD
      && (OP_SIZE == SZ_BYTE || OP_IS_LOAD && OP_DEST_PTR) || !OP_USE_PTR && OP_SIZE == SZ_BYTE)
      |=> OP_REFUSED && !MEM_VALID) else $error("Unsupported access taken.");
   word_align_a: assert property (MEM_VALID && $past(OP_SIZE == SZ_WORD
      && !OP_IMPLICIT_NOALIGN && !(OP_SUPPRESS_OP && OP_IS_LOAD && !OP_USE_PTR))
      |-> MEM_ADDR[1:0] == 2'h0) else $error("Misaligned word issued.");
   half_align_a: assert property (MEM_VALID && $past(OP_SIZE == SZ_HALF
      && !OP_IMPLICIT_NOALIGN && !(OP_SUPPRESS_OP && OP_IS_LOAD && !OP_USE_PTR))
      |-> MEM_ADDR[0] == 1'b0) else $error("Misaligned half issued.");
   ptr_still_faults_a: assert property (OP_VALID && OP_KIND == OP_ACCESS && OP_USE_PTR
      && OP_IS_LOAD && OP_SUPPRESS_OP && OP_SIZE == SZ_WORD && !OP_IMPLICIT_NOALIGN
      |=> !MEM_VALID || MEM_ADDR[1:0] == 2'h0) else $error("Pointer fault suppressed.");
   one_answer_a: assert property ($onehot0({MEM_VALID, ALIGN_FAULT, OP_REFUSED}))
      else $error("Two answers at once.");
endmodule
bind agu_top agu_checker u_chk (.CLK_SYS, .NRST, .OP_VALID, .OP_KIND, .OP_USE_PTR, .OP_MODSRC,
   .OP_SIZE, .OP_IS_LOAD, .OP_DEST_PTR, .OP_POSTMOD, .OP_IMPLICIT_NOALIGN, .OP_SUPPRESS_OP,
   .MEM_VALID, .MEM_ADDR, .ALIGN_FAULT, .OP_REFUSED);

// *** sim/testbench.sv ***
// Self-checking bench: register bus setup, address ops, answers compared.
// Assumes agu_top with its checker bound and the memory bus model.
`timescale 1ns/1ns
module testbench
   import agu_pkg::*;
;
   logic CLK_SYS, NRST, OP_VALID, OP_USE_PTR, OP_IS_LOAD, OP_DEST_PTR, OP_POSTMOD;
   logic OP_IMPLICIT_NOALIGN, OP_SUPPRESS_OP, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_RREADY, MEM_VALID, ALIGN_FAULT, OP_REFUSED, S_AXI_AWREADY;
   logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic [2:0] OP_REG, OP_MODREG;
   logic [31:0] OP_IMM, S_AXI_WDATA, MEM_ADDR, S_AXI_RDATA, last_addr;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [3:0] S_AXI_WSTRB;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
   op_t OP_KIND;
   modsrc_t OP_MODSRC;
   size_t OP_SIZE;
   int n_access, n_mismatch, comparisons;
   agu_top u_dut (.CLK_SYS, .NRST, .OP_VALID, .OP_KIND, .OP_USE_PTR, .OP_REG, .OP_MODSRC,
      .OP_MODREG, .OP_IMM, .OP_SIZE, .OP_IS_LOAD, .OP_DEST_PTR, .OP_POSTMOD,
      .OP_IMPLICIT_NOALIGN, .OP_SUPPRESS_OP, .MEM_VALID, .MEM_ADDR, .ALIGN_FAULT, .OP_REFUSED,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
      .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
   mem_bus_model u_mem (.clk(CLK_SYS), .nrst(NRST), .mem_valid(MEM_VALID),
      .mem_addr(MEM_ADDR), .n_access(n_access), .last_addr(last_addr));
   // Free-running 50 MHz clock.
   always #10 CLK_SYS = ~CLK_SYS;
   // Compares one value and counts it.
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus write; addresses past the status words answer with an error.
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge CLK_SYS);
         aw = aw | (S_AXI_AWVALID & S_AXI_AWREADY);
         w = w | (S_AXI_WVALID & S_AXI_WREADY);
         S_AXI_AWVALID <= ~aw;
         S_AXI_WVALID <= ~w;
      end
      do @(posedge CLK_SYS); while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      chk(S_AXI_BRESP, (a >= 8'h68) ? 2'h2 : 2'h0);
   endtask
   // Bus read with expected data.
   task automatic rd(logic [7:0] a, logic [31:0] ed);
      @(posedge CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge CLK_SYS); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK_SYS); while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      chk(S_AXI_RDATA, ed);
      chk(S_AXI_RRESP, (a >= 8'h68) ? 2'h2 : 2'h0);
   endtask
   // One decode op; e is {access, fault, refused} a cycle later.
   task automatic op(op_t k, logic [3:0] r, modsrc_t ms, logic [2:0] mr, size_t sz,
      logic [4:0] f, logic [2:0] e, logic [31:0] a);
      @(posedge CLK_SYS);
      OP_VALID <= 1'b1;
      OP_KIND <= k;
      {OP_USE_PTR, OP_REG} <= r;
      OP_MODSRC <= ms;
      OP_MODREG <= mr;
      OP_SIZE <= sz;
      {OP_IS_LOAD, OP_DEST_PTR, OP_POSTMOD, OP_IMPLICIT_NOALIGN, OP_SUPPRESS_OP} <= f;
      @(posedge CLK_SYS);
      OP_VALID <= 1'b0;
      #1;
      chk({MEM_VALID, ALIGN_FAULT, OP_REFUSED}, e);
      if (e[2])
         chk(MEM_ADDR, a);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cuts a hang short.
   initial
   begin
      #100000;
      n_mismatch++;
      close_out();
   end
   // Main sequence.
   initial
   begin
      {CLK_SYS, NRST, OP_VALID, OP_USE_PTR, OP_IS_LOAD, OP_DEST_PTR, OP_POSTMOD} = '0;
      {OP_IMPLICIT_NOALIGN, OP_SUPPRESS_OP, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
      {S_AXI_ARVALID, S_AXI_RREADY, OP_REG, OP_MODREG, S_AXI_WDATA} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR} = '0;
      n_mismatch = 0;
      comparisons = 0;
      OP_IMM = 32'h4;
      S_AXI_WSTRB = 4'hF;
      OP_KIND = OP_NONE;
      OP_MODSRC = MOD_MREG;
      OP_SIZE = SZ_WORD;
      repeat (12) @(posedge CLK_SYS);
      NRST <= 1'b1;
      rd(8'h70, 32'h0);
      wr(8'h7C, 32'h1);
      wr(8'h20, 32'h100);
      wr(8'h30, 32'h10);
      wr(8'h00, 32'h10C);
      wr(8'h10, 32'h8);
      wr(8'h14, 32'hFFFFFFF8);
      wr(8'h04, 32'hFFFFFFFC);
      wr(8'h18, 32'h8);
      wr(8'h44, 32'h200);
      wr(8'h48, 32'h4);
      wr(8'h4C, 32'h302);
      wr(8'h08, 32'h302);
      op(OP_ACCESS, 4'h0, MOD_MREG, 3'h0, SZ_WORD, 5'h14, 3'h4, 32'h10C);
      rd(8'h00, 32'h104);
      op(OP_ACCESS, 4'h0, MOD_MREG, 3'h1, SZ_WORD, 5'h14, 3'h4, 32'h104);
      rd(8'h00, 32'h10C);
      op(OP_MODIFY, 4'h0, MOD_IMM, 3'h0, SZ_WORD, 5'h00, 3'h0, 32'h0);
      rd(8'h00, 32'h100);
      op(OP_ACCESS, 4'h1, MOD_MREG, 3'h2, SZ_WORD, 5'h14, 3'h4, 32'hFFFFFFFC);
      rd(8'h04, 32'h4);
      op(OP_ACCESS, 4'h9, MOD_PREG, 3'h2, SZ_WORD, 5'h14, 3'h4, 32'h200);
      op(OP_ACCESS, 4'h0, MOD_PREG, 3'h0, SZ_WORD, 5'h14, 3'h1, 32'h0);
      op(OP_ACCESS, 4'h9, MOD_PREG, 3'h2, SZ_BYTE, 5'h04, 3'h1, 32'h0);
      op(OP_ACCESS, 4'h9, MOD_PREG, 3'h2, SZ_WORD, 5'h1C, 3'h1, 32'h0);
      rd(8'h44, 32'h204);
      op(OP_ACCESS, 4'hB, MOD_PREG, 3'h2, SZ_WORD, 5'h11, 3'h2, 32'h0);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_WORD, 5'h11, 3'h4, 32'h302);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_WORD, 5'h01, 3'h2, 32'h0);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_HALF, 5'h10, 3'h4, 32'h302);
      wr(8'h08, 32'h301);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_HALF, 5'h10, 3'h2, 32'h0);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_HALF, 5'h12, 3'h4, 32'h301);
      op(OP_ACCESS, 4'h2, MOD_MREG, 3'h0, SZ_WORD, 5'h14, 3'h2, 32'h0);
      rd(8'h08, 32'h309);
      rd(8'h60, 32'h7);
      rd(8'h64, 32'h301);
      wr(8'h60, 32'h7);
      op(OP_NONE, 4'h0, MOD_MREG, 3'h0, SZ_WORD, 5'h00, 3'h1, 32'h0);
      rd(8'h60, 32'h2);
      S_AXI_WSTRB <= 4'h1;
      wr(8'h4C, 32'hFFFFFFAA);
      S_AXI_WSTRB <= 4'hF;
      rd(8'h4C, 32'h3AA);
      chk(n_access, 32'h7);
      chk(last_addr, 32'h301);
      close_out();
   end
endmodule
